//--- logic/acr_pkg.sv
// Purpose: shared constants and types for the analog configuration register bank
// Assumes: eight-bit registers on a six-bit register port
// Notes: offsets, field positions and baseline values live here only
package acr_pkg;
   // ----------------------------------------
   // register port
   // ----------------------------------------
   localparam int ACR_AW = 6; // address width of the register port
   localparam int ACR_DW = 8; // data width of every register
   localparam logic [5:0] ACR_OFS_MAIN = 6'h00; // main setup register
   localparam logic [5:0] ACR_OFS_SLEEP = 6'h01; // block sleep control register
   // ----------------------------------------
   // main setup fields
   // ----------------------------------------
   localparam int ACR_MAIN_COARSE_EN = 6; // coarse offset dac enable
   localparam int ACR_MAIN_FINE_EN = 5; // fine offset dac enable
   localparam int ACR_MAIN_GATE_EN = 3; // restore request gating enable
   localparam int ACR_MAIN_GAIN2X = 2; // front stage double gain
   localparam int ACR_MAIN_DBL_SMP = 0; // double_sampling enable
   localparam logic [7:0] ACR_MAIN_WMASK = 8'h6f; // bits that hold state
   localparam logic [7:0] ACR_MAIN_RST = 8'h04; // baseline value
   // ----------------------------------------
   // sleep control fields
   // ----------------------------------------
   localparam int ACR_SLP_MASTER = 7; // master sleep
   localparam int ACR_SLP_LEVEL = 6; // restore_level_source sleep
   localparam int ACR_SLP_REF2 = 5; // second channel reference buffer sleep
   localparam int ACR_SLP_REF1 = 4; // first channel reference buffer sleep
   localparam logic [7:0] ACR_SLEEP_RST = 8'h00; // baseline value
   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic coarse_dac_en; // coarse offset dac on
      logic fine_dac_en; // fine offset dac on
      logic gain_2x; // double gain in sampling stage
      logic double_sampling; // correlated double sampling on
   } acr_front_t;
   typedef struct packed {
      logic restore_level_source; // clamp level source asleep
      logic ref_buf2; // second reference buffer asleep
      logic ref_buf1; // first reference buffer asleep
      logic rest; // bits 3..0 or master asleep
   } acr_sleep_t;
endpackage

//--- logic/acr_restore_gate.sv
// Purpose: gates the external restore request by the internal restore window
// Assumes: both inputs synchronous to ref_clk
// Notes: purely combinational
`timescale 1ns/10ps
module acr_restore_gate
   import acr_pkg::*;
(
   input wire logic gate_en,
   input wire logic restore_request_pin,
   input wire logic restore_window,
   output logic restore_out
);
   // ----------------------------------------
   // gating
   // ----------------------------------------
   // pass straight or and with the window
   assign restore_out = gate_en ? (restore_request_pin & restore_window) : restore_request_pin;
endmodule

//--- logic/acr_sleep_decode.sv
// Purpose: turns the sleep control register into per-block sleep levels
// Assumes: register value already held in flip-flops
// Notes: master bit overrides every other bit
`timescale 1ns/10ps
module acr_sleep_decode
   import acr_pkg::*;
(
   input wire logic [7:0] sleep_reg,
   output acr_sleep_t sleep_out
);
   // ----------------------------------------
   // decode
   // ----------------------------------------
   wire logic master = sleep_reg[ACR_SLP_MASTER]; // master sleep
   assign sleep_out.restore_level_source = master | sleep_reg[ACR_SLP_LEVEL];
   assign sleep_out.ref_buf2 = master | sleep_reg[ACR_SLP_REF2];
   assign sleep_out.ref_buf1 = master | sleep_reg[ACR_SLP_REF1];
   assign sleep_out.rest = master | (|sleep_reg[3:0]);
endmodule

//--- logic/acr_bank.sv
// Purpose: analog configuration register bank with setup and sleep control
// Assumes: single 100 MHz ref_clk, synchronous active-high rst
// Notes: read data appear one cycle after the read strobe and only then
`timescale 1ns/10ps
module acr_bank
   import acr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic restore_request_pin,
   input wire logic restore_window,
   output logic restore_gated,
   output acr_front_t front_cfg,
   output acr_sleep_t sleep_cfg,
   output logic chip_asleep
);
   // ----------------------------------------
   // storage
   // ----------------------------------------
   logic [7:0] main_q; // main setup register
   logic [7:0] sleep_q; // sleep control register
   logic [7:0] rdata_q; // read data register
   acr_front_t front_bits; // front configuration taken from the setup register
   // ----------------------------------------
   // decode
   // ----------------------------------------
   // true when the port index selects the register at the given offset
   function automatic logic addr_hit(input logic [5:0] a, input logic [5:0] ofs);
      return (a == ofs);
   endfunction
   wire logic hit_main = addr_hit(reg_addr, ACR_OFS_MAIN); // main setup selected
   wire logic hit_sleep = addr_hit(reg_addr, ACR_OFS_SLEEP); // sleep control selected
   wire logic wr_main = reg_wr & hit_main; // write to main setup
   wire logic wr_sleep = reg_wr & hit_sleep; // write to sleep control
   // unmapped addresses read as zero
   wire logic [7:0] rd_mux = hit_main ? main_q : (hit_sleep ? sleep_q : 8'h00);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   // setup bits 7 and 4 never store, read as zero
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         main_q <= ACR_MAIN_RST;
         sleep_q <= ACR_SLEEP_RST;
      end else begin
         if (wr_main) begin
            main_q <= reg_wdata & ACR_MAIN_WMASK;
         end
         if (wr_sleep) begin
            sleep_q <= reg_wdata;
         end
      end
   end
   // read data stand for one cycle only
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= reg_rd ? rd_mux : 8'h00;
      end
   end
   assign reg_rdata = rdata_q;
   // ----------------------------------------
   // front stage controls
   // ----------------------------------------
   assign front_bits.coarse_dac_en = main_q[ACR_MAIN_COARSE_EN];
   assign front_bits.fine_dac_en = main_q[ACR_MAIN_FINE_EN];
   assign front_bits.gain_2x = main_q[ACR_MAIN_GAIN2X];
   assign front_bits.double_sampling = main_q[ACR_MAIN_DBL_SMP];
   assign front_cfg = front_bits;
   assign chip_asleep = sleep_q[ACR_SLP_MASTER];
   // ----------------------------------------
   // submodules
   // ----------------------------------------
   acr_restore_gate acr_restore_gate_inst (
      .gate_en(main_q[ACR_MAIN_GATE_EN]),
      .restore_request_pin(restore_request_pin),
      .restore_window(restore_window),
      .restore_out(restore_gated)
   );
   acr_sleep_decode acr_sleep_decode_inst (
      .sleep_reg(sleep_q),
      .sleep_out(sleep_cfg)
   );
   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_GATE_ON: assert property (@(posedge ref_clk) disable iff (rst)
      main_q[3] |-> (restore_gated == (restore_request_pin & restore_window)))
      else $error("restore gating wrong when enabled");
   AST_GATE_OFF: assert property (@(posedge ref_clk) disable iff (rst)
      !main_q[3] |-> (restore_gated == restore_request_pin))
      else $error("restore passes wrong when gating off");
   AST_GAIN: assert property (@(posedge ref_clk) disable iff (rst)
      wr_main |=> (front_cfg.gain_2x == $past(reg_wdata[2])))
      else $error("gain mode not taken from write");
   AST_DBL: assert property (@(posedge ref_clk) disable iff (rst)
      wr_main |=> (front_cfg.double_sampling == $past(reg_wdata[0])))
      else $error("double sampling not taken from write");
   AST_MASTER: assert property (@(posedge ref_clk) disable iff (rst)
      sleep_q[7] |-> (sleep_cfg.restore_level_source && sleep_cfg.ref_buf1 && sleep_cfg.ref_buf2 && sleep_cfg.rest))
      else $error("master sleep does not override");
   AST_LEVEL: assert property (@(posedge ref_clk) disable iff (rst)
      !sleep_q[7] |-> (sleep_cfg.restore_level_source == sleep_q[6]))
      else $error("level source sleep wrong");
   AST_REF2: assert property (@(posedge ref_clk) disable iff (rst)
      !sleep_q[7] |-> (sleep_cfg.ref_buf2 == sleep_q[5]))
      else $error("second reference sleep wrong");
   AST_REF1: assert property (@(posedge ref_clk) disable iff (rst)
      !sleep_q[7] |-> (sleep_cfg.ref_buf1 == sleep_q[4]))
      else $error("first reference sleep wrong");
   AST_READBACK: assert property (@(posedge ref_clk) disable iff (rst)
      (wr_sleep ##1 (reg_rd && hit_sleep && !reg_wr)) |=> (reg_rdata == $past(reg_wdata, 2)))
      else $error("sleep register readback wrong");
   AST_RD_ONE: assert property (@(posedge ref_clk) disable iff (rst)
      !reg_rd |=> (reg_rdata == 8'h00))
      else $error("read data stand outside read cycle");

   // ----------------------------------------
   // gating checks
   // ----------------------------------------

   // no request in means no request out,
   // whatever the window and the gating bit say
   AST_GATE_IDLE: assert property (@(posedge ref_clk) disable iff (rst)
      !restore_request_pin |-> !restore_gated)
      else $error("restore request appears with no input request");

   // with gating on, a closed window must block
   // the request completely
   AST_GATE_BLOCK: assert property (@(posedge ref_clk) disable iff (rst)
      (main_q[ACR_MAIN_GATE_EN] && !restore_window) |-> !restore_gated)
      else $error("closed window does not block request");

   // with gating on and the window open the request
   // passes through unchanged
   AST_GATE_WIN: assert property (@(posedge ref_clk) disable iff (rst)
      (main_q[ACR_MAIN_GATE_EN] && restore_window) |-> (restore_gated == restore_request_pin))
      else $error("open window does not pass request");

   // ----------------------------------------
   // front stage checks
   // ----------------------------------------

   // gain mode only moves on a write to the setup register,
   // never on a read or an unmapped write
   AST_GAIN_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
      !wr_main |=> $stable(front_cfg.gain_2x))
      else $error("gain mode changed without a write");

   // sampling method only moves on a write to the setup register,
   // so the analog path never switches mode on its own
   AST_DBL_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
      !wr_main |=> $stable(front_cfg.double_sampling))
      else $error("sampling method changed without a write");

   // coarse offset dac enable follows the written bit
   // one cycle after the write strobe
   AST_COARSE: assert property (@(posedge ref_clk) disable iff (rst)
      wr_main |=> (front_cfg.coarse_dac_en == $past(reg_wdata[ACR_MAIN_COARSE_EN])))
      else $error("coarse dac enable not taken from write");

   // fine offset dac enable follows the written bit
   // one cycle after the write strobe
   AST_FINE: assert property (@(posedge ref_clk) disable iff (rst)
      wr_main |=> (front_cfg.fine_dac_en == $past(reg_wdata[ACR_MAIN_FINE_EN])))
      else $error("fine dac enable not taken from write");

   // both offset dac enables keep their value
   // while no setup write arrives
   AST_COARSE_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
      !wr_main |=> ($stable(front_cfg.coarse_dac_en) && $stable(front_cfg.fine_dac_en)))
      else $error("offset dac enables changed without a write");

   // ----------------------------------------
   // sleep control checks
   // ----------------------------------------

   // the whole-chip sleep level follows the written
   // master bit one cycle after the strobe
   AST_CHIP_WR: assert property (@(posedge ref_clk) disable iff (rst)
      wr_sleep |=> (chip_asleep == $past(reg_wdata[ACR_SLP_MASTER])))
      else $error("master sleep not taken from write");

   // with the master bit clear the remaining blocks
   // sleep exactly when one of the low bits is set
   AST_REST: assert property (@(posedge ref_clk) disable iff (rst)
      !sleep_q[ACR_SLP_MASTER] |-> (sleep_cfg.rest == (|sleep_q[3:0])))
      else $error("low sleep bits not honoured");

   // whole-chip sleep forces every block level high,
   // seen from the outputs rather than the register
   AST_ASLEEP_ALL: assert property (@(posedge ref_clk) disable iff (rst)
      chip_asleep |-> (sleep_cfg == 4'hf))
      else $error("a block stays awake under master sleep");

   // level source sleep follows its written bit
   // when the write leaves the master bit clear
   AST_LEVEL_WR: assert property (@(posedge ref_clk) disable iff (rst)
      (wr_sleep && !reg_wdata[ACR_SLP_MASTER]) |=> (sleep_cfg.restore_level_source == $past(reg_wdata[ACR_SLP_LEVEL])))
      else $error("level source sleep not taken from write");

   // second reference buffer sleep follows its written bit
   // when the write leaves the master bit clear
   AST_REF2_WR: assert property (@(posedge ref_clk) disable iff (rst)
      (wr_sleep && !reg_wdata[ACR_SLP_MASTER]) |=> (sleep_cfg.ref_buf2 == $past(reg_wdata[ACR_SLP_REF2])))
      else $error("second reference sleep not taken from write");

   // first reference buffer sleep follows its written bit
   // when the write leaves the master bit clear
   AST_REF1_WR: assert property (@(posedge ref_clk) disable iff (rst)
      (wr_sleep && !reg_wdata[ACR_SLP_MASTER]) |=> (sleep_cfg.ref_buf1 == $past(reg_wdata[ACR_SLP_REF1])))
      else $error("first reference sleep not taken from write");

   // level source stays fully powered while neither
   // its own bit nor the master bit is set
   AST_LEVEL_AWAKE: assert property (@(posedge ref_clk) disable iff (rst)
      (!sleep_q[ACR_SLP_MASTER] && !sleep_q[ACR_SLP_LEVEL]) |-> !sleep_cfg.restore_level_source)
      else $error("level source asleep without a sleep bit");

   // second reference buffer stays fully powered while neither
   // its own bit nor the master bit is set
   AST_REF2_AWAKE: assert property (@(posedge ref_clk) disable iff (rst)
      (!sleep_q[ACR_SLP_MASTER] && !sleep_q[ACR_SLP_REF2]) |-> !sleep_cfg.ref_buf2)
      else $error("second reference asleep without a sleep bit");

   // first reference buffer stays fully powered while neither
   // its own bit nor the master bit is set
   AST_REF1_AWAKE: assert property (@(posedge ref_clk) disable iff (rst)
      (!sleep_q[ACR_SLP_MASTER] && !sleep_q[ACR_SLP_REF1]) |-> !sleep_cfg.ref_buf1)
      else $error("first reference asleep without a sleep bit");

   // ----------------------------------------
   // register storage checks
   // ----------------------------------------

   // a setup write stores the data through the mask
   // of bits that hold state
   AST_MAIN_WR: assert property (@(posedge ref_clk) disable iff (rst)
      wr_main |=> (main_q == ($past(reg_wdata) & ACR_MAIN_WMASK)))
      else $error("setup register did not store write");

   // a sleep control write stores all eight bits
   // as written
   AST_SLEEP_WR: assert property (@(posedge ref_clk) disable iff (rst)
      wr_sleep |=> (sleep_q == $past(reg_wdata)))
      else $error("sleep register did not store write");

   // the setup register holds its value
   // until the next write to it
   AST_MAIN_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
      !wr_main |=> $stable(main_q))
      else $error("setup register changed without a write");

   // the sleep control register holds its value
   // until the next write to it
   AST_SLEEP_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
      !wr_sleep |=> $stable(sleep_q))
      else $error("sleep register changed without a write");

   // setup bits 7 and 4 never hold a one,
   // so they always read back as zero
   AST_MAIN_RSVD: assert property (@(posedge ref_clk) disable iff (rst)
      (main_q & ~ACR_MAIN_WMASK) == 8'h00)
      else $error("reserved setup bit holds a one");

   // a write to an unmapped index leaves
   // both registers untouched
   AST_UNMAP_WR: assert property (@(posedge ref_clk) disable iff (rst)
      (reg_wr && !hit_main && !hit_sleep) |=> ($stable(main_q) && $stable(sleep_q)))
      else $error("unmapped write changed a register");

   // ----------------------------------------
   // read port checks
   // ----------------------------------------

   // a setup read returns the register value
   // in the cycle after the strobe
   AST_RD_MAIN: assert property (@(posedge ref_clk) disable iff (rst)
      (reg_rd && hit_main) |=> (reg_rdata == $past(main_q)))
      else $error("setup read returned wrong data");

   // a sleep control read returns the register value
   // in the cycle after the strobe
   AST_RD_SLEEP: assert property (@(posedge ref_clk) disable iff (rst)
      (reg_rd && hit_sleep) |=> (reg_rdata == $past(sleep_q)))
      else $error("sleep read returned wrong data");

   // a read of an unmapped index returns zero
   // in the cycle after the strobe
   AST_RD_UNMAP: assert property (@(posedge ref_clk) disable iff (rst)
      (reg_rd && !hit_main && !hit_sleep) |=> (reg_rdata == 8'h00))
      else $error("unmapped read returned nonzero data");
endmodule

//--- test/tb_analog_config_register_bank.sv
// Purpose: self-checking bench for the analog configuration register bank
// Assumes: acr_bank with assertions inside, register port read data one cycle late
// Notes: every scenario is a task that drives the ports and judges the answer
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin n_errors++; \
   $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tb_analog_config_register_bank;
   import acr_pkg::*;
   // ----------------------------------------
   // signals and counters
   // ----------------------------------------
   logic ref_clk = 1'b0; // 100 mhz clock
   logic rst = 1'b1; // synchronous reset
   logic [5:0] reg_addr = 6'h00; // register index
   logic [7:0] reg_wdata = 8'h00; // write data
   logic reg_wr = 1'b0; // write strobe
   logic reg_rd = 1'b0; // read strobe
   logic [7:0] reg_rdata; // read data
   logic restore_request_pin = 1'b0; // external restore request
   logic restore_window = 1'b0; // internal restore window
   logic restore_gated; // gated request
   acr_front_t front_cfg; // front end settings
   acr_sleep_t sleep_cfg; // per-block sleep levels
   logic chip_asleep; // master sleep
   int n_errors = 0; // mismatches
   int cmp_count = 0; // comparisons made
   logic [7:0] rv; // last read value
   acr_bank acr_bank_inst (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .restore_request_pin(restore_request_pin),
      .restore_window(restore_window), .restore_gated(restore_gated), .front_cfg(front_cfg),
      .sleep_cfg(sleep_cfg), .chip_asleep(chip_asleep));
   // ----------------------------------------
   // clock, verdict and register port tasks
   // ----------------------------------------
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic give_verdict();
      if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // one-cycle write, then a quiet cycle so strobes never collide
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
   endtask
   // one-cycle read, data taken in the cycle after the strobe
   task automatic rd(input logic [5:0] a);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
      @(posedge ref_clk);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   // baseline values after reset, read back through the port and seen at the outputs
   task automatic t_reset();
      rd(ACR_OFS_MAIN); `CHK("main baseline", 8'h04, rv)
      rd(ACR_OFS_SLEEP); `CHK("sleep baseline", 8'h00, rv)
      `CHK("front baseline", 4'h2, front_cfg)
      `CHK("sleep out baseline", 4'h0, sleep_cfg)
   endtask
   // each setup bit alone and then all bits, read back through the mask
   task automatic t_main();
      logic [7:0] v;
      for (int i = 0; i < 9; i++) begin
         v = (i == 8) ? 8'hff : (8'h01 << i);
         wr(ACR_OFS_MAIN, v);
         rd(ACR_OFS_MAIN); `CHK("main readback", v & 8'h6f, rv)
         `CHK("front cfg", {v[6], v[5], v[2], v[0]}, front_cfg)
      end
   endtask
   // request gating in both settings over all input pairs
   task automatic t_gate();
      for (int g = 0; g < 2; g++) begin
         wr(ACR_OFS_MAIN, g ? 8'h08 : 8'h00);
         for (int k = 0; k < 4; k++) begin
            restore_request_pin <= k[0]; restore_window <= k[1];
            @(posedge ref_clk);
            #1 `CHK("restore gated", k[0] & (g == 0 || k[1]), restore_gated)
         end
      end
   endtask
   // every mix of sleep bits 7..4, bit 0 copied from bit 4, so bits 6..4 alone and under the master bit
   task automatic t_sleep();
      logic [7:0] v;
      logic m;
      for (int i = 0; i < 16; i++) begin
         v = {i[3], i[2], i[1], i[0], 3'h0, i[0]};
         m = v[7];
         wr(ACR_OFS_SLEEP, v);
         `CHK("sleep cfg", {m | v[6], m | v[5], m | v[4], m | (|v[3:0])}, sleep_cfg)
         `CHK("chip asleep", m, chip_asleep)
         rd(ACR_OFS_SLEEP); `CHK("sleep readback", v, rv)
      end
   endtask
   // unmapped write ignored, read returns zero, data stand one cycle only
   task automatic t_unmapped();
      wr(ACR_OFS_MAIN, 8'h61);
      wr(6'h05, 8'hff);
      rd(6'h05); `CHK("unmapped read", 8'h00, rv)
      rd(ACR_OFS_MAIN); `CHK("main kept", 8'h61, rv)
      #1 `CHK("rdata after read", 8'h00, reg_rdata)
   endtask
   // write then read with no gap, the read sees the new value
   task automatic t_b2b();
      reg_wr <= 1'b1;
      reg_addr <= ACR_OFS_SLEEP;
      reg_wdata <= 8'h5a;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 `CHK("back to back read", 8'h5a, reg_rdata)
      `CHK("back to back sleep cfg", 4'hb, sleep_cfg)
      @(posedge ref_clk);
   endtask
   // reset in mid-run brings back the baseline values
   task automatic t_rst();
      wr(ACR_OFS_MAIN, 8'h6f);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      `CHK("front after reset", 4'h2, front_cfg)
      `CHK("sleep cfg after reset", 4'h0, sleep_cfg)
      `CHK("asleep after reset", 1'b0, chip_asleep)
      rd(ACR_OFS_MAIN);
      `CHK("main after reset", 8'h04, rv)
   endtask
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      t_reset();
      t_main();
      t_gate();
      t_sleep();
      t_b2b();
      t_unmapped();
      t_rst();
      give_verdict();
   end
   initial begin
      repeat (3000) @(posedge ref_clk);
      n_errors++;
      give_verdict();
   end
endmodule
